/* logic/ictu_tag_unit.sv */
module ictu_tag_unit
  import ictu_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Processor side
  input wire logic tag_flush_in,
  input wire logic valid_set_strobe,
  input wire logic miss_state,
  input wire logic [ICTU_WORD_W-1:0] pc_bus,
  input wire logic [ICTU_WORD_W-1:0] alu_result_inverted,
  output logic fetch_hit,
  output logic [ICTU_WAYS-1:0] block_select_onehot,
  output logic [ICTU_WORD_W-1:0] external_address_out,
  // Register bus
  input wire logic [ICTU_AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ICTU_AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ********************************************************************
  // State
  // ********************************************************************
  typedef struct packed {
    logic [ICTU_ENTRIES-1:0][ICTU_TAG_W-1:0] tag;
    logic [ICTU_ENTRIES-1:0] live;
    logic [ICTU_ENTRIES-1:0][ICTU_WORDS-1:0] invalid;
    logic [ICTU_WAYS-1:0] ring;
    logic [ICTU_WORD_W-1:0] pc_q;
    logic hit;
    logic [ICTU_WAYS-1:0] sel;
    logic [ICTU_WORD_W-1:0] addr_out;
    logic cache_off;
    logic test_mode;
    logic [ICTU_ENTRY_BITS-1:0] test_index;
    ictu_wr_e wr;
    logic [ICTU_AXI_ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ictu_state_s;

  localparam ictu_state_s ICTU_RESET_STATE = '{
    invalid: '1,
    ring: ICTU_RING_FIRST,
    wr: ICTU_WR_IDLE,
    default: '0
  };

  ictu_state_s r;
  ictu_state_s next_r;

  function automatic logic [ICTU_WAYS-1:0] ictu_ring_step(input logic [ICTU_WAYS-1:0] ring);
    ictu_ring_step = {ring[ICTU_WAYS-2:0], ring[ICTU_WAYS-1]};
  endfunction

  function automatic logic [31:0] ictu_merge(input logic [31:0] old_word,
                                             input logic [31:0] new_word,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_word[b*8 +: 8];
      end
    end
    ictu_merge = res;
  endfunction

  // ********************************************************************
  // Tag compare
  // ********************************************************************
  logic [ICTU_SET_W-1:0] set_idx;
  logic [ICTU_WORD_BITS-1:0] word_idx;
  logic [ICTU_TAG_W-1:0] fetch_tag;
  logic [ICTU_ENTRIES-1:0] match_all;
  logic [ICTU_WAYS-1:0] way_match;
  logic blk_hit;
  logic [ICTU_WAY_BITS-1:0] hit_way;
  logic [ICTU_WAY_BITS-1:0] ring_way;
  logic [ICTU_ENTRY_BITS-1:0] hit_entry;
  logic [ICTU_ENTRY_BITS-1:0] refill_entry;
  logic word_valid;
  logic fetch_active;
  logic refill;
  logic ring_advance;

  assign set_idx = pc_bus[ICTU_SET_LSB +: ICTU_SET_W];
  assign word_idx = pc_bus[ICTU_WORD_LSB +: ICTU_WORD_BITS];
  assign fetch_tag = {pc_bus[ICTU_TAG_TOP], pc_bus[ICTU_TAG_MID_HI:ICTU_TAG_MID_LO]};

  // Every entry compares in the same cycle; a cleared reset cell blocks the match.
  for (genvar g = 0; g < ICTU_ENTRIES; g++) begin : g_entry
    assign match_all[g] = r.live[g] && (r.tag[g] == fetch_tag);
  end

  always_comb begin
    way_match = '0;
    hit_way = '0;
    ring_way = '0;
    for (int w = 0; w < ICTU_WAYS; w++) begin
      way_match[w] = match_all[{set_idx, ICTU_WAY_BITS'(w)}];
      if (way_match[w]) begin
        hit_way = ICTU_WAY_BITS'(w);
      end
      if (r.ring[w]) begin
        ring_way = ICTU_WAY_BITS'(w);
      end
    end
  end

  assign blk_hit = |way_match;
  assign hit_entry = {set_idx, hit_way};
  assign refill_entry = {set_idx, ring_way};
  // Cells hold 0 for a valid word; on a block miss no valid bit is looked at.
  assign word_valid = blk_hit && !r.invalid[hit_entry][word_idx];
  // Test mode and cache off both keep fetches from touching the tag store.
  assign fetch_active = !r.test_mode && !r.cache_off;
  assign refill = fetch_active && !blk_hit;
  assign ring_advance = refill || (fetch_active && blk_hit && |(r.ring & way_match));

  // ********************************************************************
  // Register bus
  // ********************************************************************
  logic aw_fire;
  logic w_fire;
  logic do_write;
  logic [ICTU_AXI_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] wr_old;
  logic [31:0] wr_new;
  logic wr_ok;

  assign s_axi_awready = (r.wr == ICTU_WR_IDLE) || (r.wr == ICTU_WR_DATA);
  assign s_axi_wready = (r.wr == ICTU_WR_IDLE) || (r.wr == ICTU_WR_ADDR);
  assign s_axi_bvalid = (r.wr == ICTU_WR_RESP);
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign aw_fire = s_axi_awvalid && s_axi_awready;
  assign w_fire = s_axi_wvalid && s_axi_wready;
  assign wr_addr = (r.wr == ICTU_WR_ADDR) ? r.awaddr : s_axi_awaddr;
  assign wr_data = (r.wr == ICTU_WR_DATA) ? r.wdata : s_axi_wdata;
  assign wr_strb = (r.wr == ICTU_WR_DATA) ? r.wstrb : s_axi_wstrb;
  assign do_write = (aw_fire || r.wr == ICTU_WR_ADDR) && (w_fire || r.wr == ICTU_WR_DATA);

  always_comb begin
    rd_word = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      ICTU_REG_CTRL: begin
        rd_word[ICTU_CTRL_OFF_BIT] = r.cache_off;
        rd_word[ICTU_CTRL_TEST_BIT] = r.test_mode;
      end
      ICTU_REG_STATUS: begin
        rd_word[ICTU_WAYS-1:0] = r.ring;
        rd_word[ICTU_STATUS_HIT_BIT] = r.hit;
      end
      ICTU_REG_TEST_INDEX: rd_word[ICTU_ENTRY_BITS-1:0] = r.test_index;
      ICTU_REG_TEST_TAG: begin
        rd_word[ICTU_TAG_W-1:0] = r.tag[r.test_index];
        rd_word[ICTU_LIVE_BIT] = r.live[r.test_index];
      end
      ICTU_REG_TEST_VALID: rd_word[ICTU_WORDS-1:0] = ~r.invalid[r.test_index];
      default: rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    wr_old = '0;
    wr_ok = 1'b1;
    unique case (wr_addr)
      ICTU_REG_CTRL: begin
        wr_old[ICTU_CTRL_OFF_BIT] = r.cache_off;
        wr_old[ICTU_CTRL_TEST_BIT] = r.test_mode;
      end
      ICTU_REG_STATUS: wr_old = '0;
      ICTU_REG_TEST_INDEX: wr_old[ICTU_ENTRY_BITS-1:0] = r.test_index;
      ICTU_REG_TEST_TAG: begin
        wr_old[ICTU_TAG_W-1:0] = r.tag[r.test_index];
        wr_old[ICTU_LIVE_BIT] = r.live[r.test_index];
        wr_ok = r.test_mode;
      end
      ICTU_REG_TEST_VALID: begin
        wr_old[ICTU_WORDS-1:0] = ~r.invalid[r.test_index];
        wr_ok = r.test_mode;
      end
      default: wr_ok = 1'b0;
    endcase
  end

  assign wr_new = ictu_merge(wr_old, wr_data, wr_strb);

  // ********************************************************************
  // Next state
  // ********************************************************************
  always_comb begin
    next_r = r;
    next_r.pc_q = pc_bus;
    next_r.hit = word_valid && fetch_active;
    next_r.sel = (fetch_active && blk_hit) ? ICTU_WAYS'(1) << hit_way : '0;
    next_r.addr_out = miss_state ? r.pc_q : ~alu_result_inverted;
    if (refill) begin
      next_r.tag[refill_entry] = fetch_tag;
      next_r.live[refill_entry] = 1'b1;
      next_r.invalid[refill_entry] = '1;
    end
    // The strobe can only land on a line that hits, so a refill never collides.
    if (valid_set_strobe && fetch_active && blk_hit) begin
      next_r.invalid[hit_entry][word_idx] = 1'b0;
    end
    if (ring_advance) begin
      next_r.ring = ictu_ring_step(r.ring);
    end
    // Read channel; a test-valid read in test mode steps through the entries.
    if (s_axi_arvalid && s_axi_arready) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = rd_word;
      next_r.rresp = rd_ok ? ICTU_RESP_OKAY : ICTU_RESP_SLVERR;
      if (rd_ok && r.test_mode && s_axi_araddr == ICTU_REG_TEST_VALID) begin
        next_r.test_index = r.test_index + 5'h1;
      end
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    // Write channel.
    unique case (r.wr)
      ICTU_WR_IDLE: begin
        if (do_write) begin
          next_r.wr = ICTU_WR_RESP;
        end else if (aw_fire) begin
          next_r.wr = ICTU_WR_ADDR;
        end else if (w_fire) begin
          next_r.wr = ICTU_WR_DATA;
        end
      end
      ICTU_WR_ADDR, ICTU_WR_DATA: begin
        if (do_write) begin
          next_r.wr = ICTU_WR_RESP;
        end
      end
      ICTU_WR_RESP: begin
        if (s_axi_bready) begin
          next_r.wr = ICTU_WR_IDLE;
        end
      end
    endcase
    if (aw_fire) begin
      next_r.awaddr = s_axi_awaddr;
    end
    if (w_fire) begin
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      next_r.bresp = wr_ok ? ICTU_RESP_OKAY : ICTU_RESP_SLVERR;
      if (wr_ok) begin
        unique case (wr_addr)
          ICTU_REG_CTRL: begin
            next_r.cache_off = wr_new[ICTU_CTRL_OFF_BIT];
            next_r.test_mode = wr_new[ICTU_CTRL_TEST_BIT];
          end
          ICTU_REG_TEST_INDEX: next_r.test_index = wr_new[ICTU_ENTRY_BITS-1:0];
          ICTU_REG_TEST_TAG: begin
            next_r.tag[r.test_index] = wr_new[ICTU_TAG_W-1:0];
            next_r.live[r.test_index] = wr_new[ICTU_LIVE_BIT];
          end
          ICTU_REG_TEST_VALID: begin
            next_r.invalid[r.test_index] = ~wr_new[ICTU_WORDS-1:0];
            next_r.test_index = r.test_index + 5'h1;
          end
          default: next_r.bresp = ICTU_RESP_OKAY;
        endcase
      end
    end
    // Flush clears live over a same-cycle refill outside test mode; in test mode live is kept, so tag writes survive.
    if (tag_flush_in) begin
      next_r.ring = ICTU_RING_FIRST;
      if (!r.test_mode) begin
        next_r.live = '0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= ICTU_RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  assign fetch_hit = r.hit;
  assign block_select_onehot = r.sel;
  assign external_address_out = r.addr_out;

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_off_forces_miss: assert property (r.cache_off |=> !fetch_hit)
    else $error("fetch hit reported while cache is off");

  chk_hit_needs_valid: assert property (fetch_hit |-> $past(word_valid))
    else $error("fetch hit without a valid word");

  chk_select_onehot: assert property ($onehot0(block_select_onehot)
                                      and (fetch_hit |-> $onehot(block_select_onehot)))
    else $error("block select is not one-hot");

  chk_addr_from_pc: assert property (aresetn && miss_state
                                     |=> external_address_out == $past(r.pc_q))
    else $error("miss address does not carry the held pc");

  chk_addr_from_alu: assert property (aresetn && !miss_state
                                      |=> external_address_out == ~$past(alu_result_inverted))
    else $error("address does not carry the result bus");

  chk_ring_onehot: assert property ($onehot(r.ring))
    else $error("ring counter lost its single bit");

  chk_ring_flush: assert property (tag_flush_in |=> r.ring == ICTU_RING_FIRST)
    else $error("ring counter not at block zero after flush");

  chk_ring_step: assert property (ring_advance && !tag_flush_in
                                  |=> r.ring == ictu_ring_step($past(r.ring)))
    else $error("ring counter did not rotate");

  chk_refill_smash: assert property (refill && !tag_flush_in
                                     |=> r.invalid[$past(refill_entry)] == '1
                                         && r.live[$past(refill_entry)])
    else $error("replaced line not invalidated");

  chk_flush_no_hit: assert property (tag_flush_in && !r.test_mode
                                     |=> r.live == '0 ##1 !fetch_hit)
    else $error("tag matched after flush");

  chk_invalid_keeps_tag: assert property (fetch_active && blk_hit && !word_valid
                                          && !tag_flush_in && !do_write
                                          |=> r.tag == $past(r.tag) && r.live == $past(r.live))
    else $error("hit on invalid word rewrote the tag store");

  chk_valid_set: assert property (valid_set_strobe && fetch_active && blk_hit
                                  |=> !r.invalid[$past(hit_entry)][$past(word_idx)])
    else $error("valid bit not set by strobe");

  cov_refill: cover property (refill ##1 valid_set_strobe ##1 fetch_hit);
  cov_hit_pair: cover property (fetch_hit ##1 fetch_hit);
  cov_test_write: cover property (do_write && r.test_mode && wr_addr == ICTU_REG_TEST_TAG);
  cov_ring_wrap: cover property (ring_advance && r.ring[ICTU_WAYS-1]);

endmodule

/* logic/ictu_pkg.sv */
package ictu_pkg;

  // ********************************************************************
  // Cache geometry
  // ********************************************************************
  localparam int ICTU_SETS = 4;
  localparam int ICTU_WAYS = 8;
  localparam int ICTU_ENTRIES = ICTU_SETS * ICTU_WAYS;
  localparam int ICTU_TAG_W = 24;
  localparam int ICTU_WORDS = 16;
  localparam int ICTU_WORD_W = 32;
  localparam int ICTU_WAY_BITS = 3;
  localparam int ICTU_ENTRY_BITS = 5;

  // ********************************************************************
  // Fetch address fields (bit n of the big-endian numbering is pc[31-n])
  // ********************************************************************
  localparam int ICTU_SET_LSB = 4;
  localparam int ICTU_SET_W = 2;
  localparam int ICTU_WORD_LSB = 0;
  localparam int ICTU_WORD_BITS = 4;
  localparam int ICTU_TAG_TOP = 31;
  localparam int ICTU_TAG_MID_HI = 28;
  localparam int ICTU_TAG_MID_LO = 6;

  localparam logic [ICTU_WAYS-1:0] ICTU_RING_FIRST = 8'h01;

  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int ICTU_AXI_ADDR_W = 8;
  localparam logic [7:0] ICTU_REG_CTRL = 8'h00;
  localparam logic [7:0] ICTU_REG_STATUS = 8'h04;
  localparam logic [7:0] ICTU_REG_TEST_INDEX = 8'h08;
  localparam logic [7:0] ICTU_REG_TEST_TAG = 8'h0c;
  localparam logic [7:0] ICTU_REG_TEST_VALID = 8'h10;
  localparam int ICTU_CTRL_OFF_BIT = 0;
  localparam int ICTU_CTRL_TEST_BIT = 1;
  localparam int ICTU_LIVE_BIT = 24;
  localparam int ICTU_STATUS_HIT_BIT = 8;
  localparam logic [1:0] ICTU_RESP_OKAY = 2'h0;
  localparam logic [1:0] ICTU_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ICTU_WR_IDLE = 2'h0,
    ICTU_WR_RESP = 2'h1,
    ICTU_WR_ADDR = 2'h2,
    ICTU_WR_DATA = 2'h3
  } ictu_wr_e;

endpackage

/* bench/ictu_pc_model.sv */
module ictu_pc_model
  import ictu_pkg::*;
(
  // Clock
  input wire logic aclk,
  // From the tag unit
  input wire logic fetch_hit,
  input wire logic [ICTU_WAYS-1:0] block_select_onehot,
  input wire logic [ICTU_WORD_W-1:0] external_address_out,
  // Value the execute unit puts on its result bus
  input wire logic [ICTU_WORD_W-1:0] alu_value,
  // To the tag unit
  output logic tag_flush_in,
  output logic valid_set_strobe,
  output logic miss_state,
  output logic [ICTU_WORD_W-1:0] pc_bus,
  output logic [ICTU_WORD_W-1:0] alu_result_inverted
);
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Processor side of the fetch path
  // ****************************************************************
  assign alu_result_inverted = ~alu_value;

  // Flush stays high from power-up so the idle PC cannot claim a way early.
  initial begin
    tag_flush_in = 1'b1;
    valid_set_strobe = 1'b0;
    miss_state = 1'b0;
    pc_bus = 32'h0;
  end

  task automatic set_flush(input logic v);
    @(posedge aclk);
    tag_flush_in <= v;
  endtask

  // One fetch; on a miss the two miss cycles follow, the first held for st extra cycles.
  task automatic fetch(input logic [31:0] pc, input int st, output logic hit,
                       output logic [7:0] sel, output logic [31:0] addr);
    @(posedge aclk);
    pc_bus <= pc;
    tag_flush_in <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    hit = fetch_hit;
    sel = block_select_onehot;
    addr = external_address_out;
    if (!hit) begin
      miss_state <= 1'b1;
      repeat (st) @(posedge aclk);
      @(posedge aclk);
      valid_set_strobe <= 1'b1;
      @(posedge aclk);
      addr = external_address_out;
      valid_set_strobe <= 1'b0;
      miss_state <= 1'b0;
    end
  endtask
endmodule

/* bench/tb_top.sv */
module tb_top
  import ictu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic flush, vset, miss, hit, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, h;
  logic [31:0] pc, alu_inv, addr_out, alu_value, wdata, rdata, a, rd;
  logic [7:0] sel, awaddr, araddr, s;
  logic [1:0] bresp, rresp, rs;
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;

  always #5 aclk = ~aclk;

  ictu_tag_unit dut (.aclk(aclk), .aresetn(aresetn), .tag_flush_in(flush),
    .valid_set_strobe(vset), .miss_state(miss), .pc_bus(pc), .alu_result_inverted(alu_inv),
    .fetch_hit(hit), .block_select_onehot(sel), .external_address_out(addr_out),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  ictu_pc_model pcu (.aclk(aclk), .fetch_hit(hit), .block_select_onehot(sel),
    .external_address_out(addr_out), .alu_value(alu_value), .tag_flush_in(flush),
    .valid_set_strobe(vset), .miss_state(miss), .pc_bus(pc), .alu_result_inverted(alu_inv));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input logic [7:0] ad, input logic [31:0] d);
    wr(ad, d, rs);
    check("bresp", {30'h0, rs}, {30'h0, ICTU_RESP_OKAY});
  endtask

  task automatic reg_chk(input logic [7:0] ad, input logic [31:0] exp);
    rdr(ad, rd, rs);
    check("rresp", {30'h0, rs}, {30'h0, ICTU_RESP_OKAY});
    check("rdata", rd, exp);
  endtask

  // A hit shows the result bus on the address pins, a miss the fetch address.
  task automatic fchk(input logic [31:0] p, input int st, input logic eh, input logic [7:0] es);
    pcu.fetch(p, st, h, s, a);
    check("fetch_hit", {31'h0, h}, {31'h0, eh});
    check("block_select", {24'h0, s}, {24'h0, es});
    check("address_out", a, eh ? alu_value : p);
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      fails++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    awaddr = 8'h0;
    araddr = 8'h0;
    wdata = 32'h0;
    alu_value = 32'h5a3c_e0f1;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    reg_chk(ICTU_REG_STATUS, 32'h0000_0001);
    reg_chk(ICTU_REG_CTRL, 32'h0000_0000);
    rdr(8'h20, rd, rs);
    check("unmapped_rresp", {30'h0, rs}, {30'h0, ICTU_RESP_SLVERR});
    check("unmapped_rdata", rd, 32'h0);
    wr(ICTU_REG_TEST_TAG, 32'h0100_0070, rs);
    check("tag_write_bresp", {30'h0, rs}, {30'h0, ICTU_RESP_SLVERR});
    fchk(32'h0000_0003, 0, 1'b0, 8'h00);
    reg_chk(ICTU_REG_STATUS, 32'h0000_0102);
    fchk(32'h0000_0003, 0, 1'b1, 8'h01);
    fchk(32'h0000_0004, 2, 1'b0, 8'h01);
    reg_chk(ICTU_REG_STATUS, 32'h0000_0102);
    for (int k = 1; k < 8; k++) begin
      fchk((k << 8) | 3, k % 2, 1'b0, 8'h00);
    end
    reg_chk(ICTU_REG_STATUS, 32'h0000_0101);
    fchk(32'h0000_0003, 0, 1'b1, 8'h01);
    reg_chk(ICTU_REG_STATUS, 32'h0000_0102);
    fchk(32'h0000_0803, 0, 1'b0, 8'h00);
    fchk(32'h0000_0103, 0, 1'b0, 8'h00);
    fchk(32'h0000_0703, 0, 1'b1, 8'h80);
    wr_ok(ICTU_REG_CTRL, 32'h1);
    fchk(32'h0000_0003, 0, 1'b0, 8'h00);
    reg_chk(ICTU_REG_STATUS, 32'h0000_0008);
    wr_ok(ICTU_REG_CTRL, 32'h0);
    fchk(32'h0000_0003, 0, 1'b1, 8'h01);
    wr_ok(ICTU_REG_CTRL, 32'h2);
    wr_ok(ICTU_REG_TEST_INDEX, 32'h5);
    wr_ok(ICTU_REG_TEST_TAG, 32'h0100_0070);
    wr_ok(ICTU_REG_TEST_VALID, 32'h0000_ffff);
    reg_chk(ICTU_REG_TEST_INDEX, 32'h6);
    wr_ok(ICTU_REG_TEST_INDEX, 32'h5);
    reg_chk(ICTU_REG_TEST_TAG, 32'h0100_0070);
    reg_chk(ICTU_REG_TEST_VALID, 32'h0000_ffff);
    reg_chk(ICTU_REG_TEST_INDEX, 32'h6);
    pcu.set_flush(1'b1);
    pcu.set_flush(1'b0);
    wr_ok(ICTU_REG_CTRL, 32'h0);
    fchk(32'h0000_1c05, 0, 1'b1, 8'h20);
    pcu.set_flush(1'b1);
    fchk(32'h0000_1c05, 0, 1'b0, 8'h00);
    reg_chk(ICTU_REG_STATUS, 32'h0000_0102);
    wrap_up();
  end
endmodule
